// *** design/pump_cfg.svh ***
// Purpose: constants for the pump, delay and power configuration slice
// Assumes: byte-wide register port, offsets are byte addresses
// Notes: all offsets, field positions and reset values live here
//
// Notes on behaviour
// - bleed current spans pump[7:6] and upper byte
// - pump bit 5 picks bleed sink or source
// - pump bit 4 enables bleed, resets off
// - delay bit 7 inverts the clock output
// - delay bits 6:0 feedback code, resets zero
// - next register bits 6:0 reference code
// - reference register bit 7 picks 3.3V logic
// - power bits 5:4 set output swing
// - power bit 3 powers down divider path
// - reference detector starts powered down, writing bit 2 low clears
// - power bit 1 controls temperature converter
`ifndef PUMP_CFG_SVH
`define PUMP_CFG_SVH

`define ADDR_W 8
`define DATA_W 8

`define OFS_PUMP_BLEED_CONTROL 8'h15
`define OFS_BLEED_CURRENT_UPPER 8'h16
`define OFS_FEEDBACK_DELAY_INVERT 8'h17
`define OFS_REFERENCE_DELAY_LEVEL 8'h18
`define OFS_OUTPUT_SWING_POWER 8'h19

`define RST_PUMP_BLEED_CONTROL 8'h00
`define RST_BLEED_CURRENT_UPPER 8'h00
`define RST_FEEDBACK_DELAY_INVERT 8'h00
`define RST_REFERENCE_DELAY_LEVEL 8'h00
`define RST_OUTPUT_SWING_POWER 8'h04

`define BLEED_LOW_MSB 7
`define BLEED_LOW_LSB 6
`define BLEED_DIR_BIT 5
`define BLEED_EN_BIT 4
`define PUMP_CUR_MSB 3
`define PUMP_CUR_LSB 0
`define INVERT_BIT 7
`define DELAY_MSB 6
`define DELAY_LSB 0
`define LEVEL_BIT 7
`define SWING_MSB 5
`define SWING_LSB 4
`define DIV_PD_BIT 3
`define RDET_PD_BIT 2
`define TEMP_PD_BIT 1
`define CALDAC_PD_BIT 0

`define BLEED_W 10
`define DELAY_W 7
`define BUF_W 25

`endif

// *** design/pump_pkg.sv ***
// Purpose: shared types of the configuration slice
// Assumes: widths from pump_cfg.svh
// Notes: types only
`include "pump_cfg.svh"
package pump_pkg;
    typedef logic [`ADDR_W-1:0] reg_addr_t;
    typedef logic [`DATA_W-1:0] reg_byte_t;
    typedef logic [`BLEED_W-1:0] bleed_code_t;
    typedef logic [`DELAY_W-1:0] delay_code_t;
    typedef logic [`BUF_W-1:0] buffered_t;
endpackage

// *** design/buffered_fields.sv ***
// Purpose: active copy of the double-buffered fields
// Assumes: shadow copy is the software-visible register contents
// Notes: active follows one cycle after the shadow when unbuffered
`timescale 1ns/1ps
`include "pump_cfg.svh"
module buffered_fields
    import pump_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire buffered_t shadow,
    input wire logic buffer_enable,
    input wire logic buffer_update,
    output buffered_t active
);
    // active loads on update, or every cycle with buffering off
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            active <= '0;
        end else if (!buffer_enable || buffer_update) begin
            active <= shadow;
        end
    end
endmodule

// *** design/pump_delay_power_cfg_regs.sv ***
// Purpose: pump, delay and power configuration registers
// Assumes: byte register port synchronous to ref_clk, one access per cycle
// Notes: reads answer one cycle later; unmapped reads return zero
`timescale 1ns/1ps
`include "pump_cfg.svh"
module pump_delay_power_cfg_regs
    import pump_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire reg_addr_t reg_addr,
    input wire reg_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output reg_byte_t reg_rdata,
    output logic reg_rvalid,
    input wire logic buffer_enable,
    input wire logic buffer_update,
    output logic [3:0] pump_current_code,
    output bleed_code_t bleed_current,
    output logic bleed_direction,
    output logic bleed_enable,
    output logic output_clock_inversion,
    output delay_code_t feedback_delay_code,
    output delay_code_t reference_delay_code,
    output logic io_logic_level_select,
    output logic [1:0] output_swing_code,
    output logic divider_power_down,
    output logic reference_detector_off,
    output logic temp_converter_off,
    output logic cal_dac_off
);
    reg_byte_t pump_bleed_control;
    reg_byte_t bleed_current_upper;
    reg_byte_t feedback_delay_invert;
    reg_byte_t reference_delay_level;
    reg_byte_t output_swing_power;
    buffered_t shadow;
    buffered_t active;
    reg_byte_t next_rdata;

    // register writes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pump_bleed_control <= `RST_PUMP_BLEED_CONTROL;
            bleed_current_upper <= `RST_BLEED_CURRENT_UPPER;
            feedback_delay_invert <= `RST_FEEDBACK_DELAY_INVERT;
            reference_delay_level <= `RST_REFERENCE_DELAY_LEVEL;
            output_swing_power <= `RST_OUTPUT_SWING_POWER;
        end else if (reg_wr) begin
            case (reg_addr)
                `OFS_PUMP_BLEED_CONTROL: begin
                    pump_bleed_control <= reg_wdata;
                end
                `OFS_BLEED_CURRENT_UPPER: begin
                    bleed_current_upper <= reg_wdata;
                end
                `OFS_FEEDBACK_DELAY_INVERT: begin
                    feedback_delay_invert <= reg_wdata;
                end
                `OFS_REFERENCE_DELAY_LEVEL: begin
                    reference_delay_level <= reg_wdata;
                end
                `OFS_OUTPUT_SWING_POWER: begin
                    // reserved pair stored as written, software owns its value
                    output_swing_power <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // read mux, no side effects on read
    always_comb begin
        case (reg_addr)
            `OFS_PUMP_BLEED_CONTROL: next_rdata = pump_bleed_control;
            `OFS_BLEED_CURRENT_UPPER: next_rdata = bleed_current_upper;
            `OFS_FEEDBACK_DELAY_INVERT: next_rdata = feedback_delay_invert;
            `OFS_REFERENCE_DELAY_LEVEL: next_rdata = reference_delay_level;
            `OFS_OUTPUT_SWING_POWER: next_rdata = output_swing_power;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // readback always shows the shadow, so software sees what it wrote
    assign shadow = {bleed_current_upper,
                     pump_bleed_control[`BLEED_LOW_MSB:`BLEED_LOW_LSB],
                     feedback_delay_invert[`INVERT_BIT],
                     feedback_delay_invert[`DELAY_MSB:`DELAY_LSB],
                     reference_delay_level[`DELAY_MSB:`DELAY_LSB]};

    buffered_fields u_buffered (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .shadow(shadow),
        .buffer_enable(buffer_enable),
        .buffer_update(buffer_update),
        .active(active)
    );

    assign bleed_current = active[24:15];
    assign output_clock_inversion = active[14];
    assign feedback_delay_code = active[13:7];
    assign reference_delay_code = active[6:0];

    assign pump_current_code = pump_bleed_control[`PUMP_CUR_MSB:`PUMP_CUR_LSB];
    assign bleed_direction = pump_bleed_control[`BLEED_DIR_BIT];
    assign bleed_enable = pump_bleed_control[`BLEED_EN_BIT];
    assign io_logic_level_select = reference_delay_level[`LEVEL_BIT];
    assign output_swing_code = output_swing_power[`SWING_MSB:`SWING_LSB];
    assign divider_power_down = output_swing_power[`DIV_PD_BIT];
    assign reference_detector_off = output_swing_power[`RDET_PD_BIT];
    assign temp_converter_off = output_swing_power[`TEMP_PD_BIT];
    assign cal_dac_off = output_swing_power[`CALDAC_PD_BIT];

    // checks
    property p_bleed_split;
        @(posedge ref_clk) disable iff (!resetn)
        reg_wr && reg_addr == `OFS_BLEED_CURRENT_UPPER && !buffer_enable ##1 !buffer_enable
        |=> bleed_current[`BLEED_W-1:2] == $past(reg_wdata, 2);
    endproperty
    a_bleed_split: assert property (p_bleed_split) else $error("bleed upper byte not applied");

    property p_bleed_dir;
        @(posedge ref_clk) disable iff (!resetn)
        reg_wr && reg_addr == `OFS_PUMP_BLEED_CONTROL |=> bleed_direction == $past(reg_wdata[`BLEED_DIR_BIT]);
    endproperty
    a_bleed_dir: assert property (p_bleed_dir) else $error("bleed direction wrong");

    property p_bleed_en;
        @(posedge ref_clk) disable iff (!resetn)
        reg_wr && reg_addr == `OFS_PUMP_BLEED_CONTROL |=> bleed_enable == $past(reg_wdata[`BLEED_EN_BIT]);
    endproperty
    a_bleed_en: assert property (p_bleed_en) else $error("bleed enable wrong");

    property p_invert_hold;
        @(posedge ref_clk) disable iff (!resetn)
        buffer_enable && !buffer_update |=> $stable(output_clock_inversion);
    endproperty
    a_invert_hold: assert property (p_invert_hold) else $error("inversion moved without update");

    property p_fb_delay;
        @(posedge ref_clk) disable iff (!resetn)
        reg_wr && reg_addr == `OFS_FEEDBACK_DELAY_INVERT && !buffer_enable ##1 !buffer_enable
        |=> feedback_delay_code == $past(reg_wdata[`DELAY_MSB:`DELAY_LSB], 2);
    endproperty
    a_fb_delay: assert property (p_fb_delay) else $error("feedback delay not applied");

    property p_ref_update;
        @(posedge ref_clk) disable iff (!resetn)
        buffer_update |=> reference_delay_code == $past(reference_delay_level[`DELAY_MSB:`DELAY_LSB]);
    endproperty
    a_ref_update: assert property (p_ref_update) else $error("reference delay missed update");

    property p_level;
        @(posedge ref_clk) disable iff (!resetn)
        reg_wr && reg_addr == `OFS_REFERENCE_DELAY_LEVEL |=> io_logic_level_select == $past(reg_wdata[`LEVEL_BIT]);
    endproperty
    a_level: assert property (p_level) else $error("logic level wrong");

    property p_swing;
        @(posedge ref_clk) disable iff (!resetn)
        reg_wr && reg_addr == `OFS_OUTPUT_SWING_POWER
        |=> output_swing_code == $past(reg_wdata[`SWING_MSB:`SWING_LSB]);
    endproperty
    a_swing: assert property (p_swing) else $error("swing code wrong");

    property p_power_bits;
        @(posedge ref_clk) disable iff (!resetn)
        reg_wr && reg_addr == `OFS_OUTPUT_SWING_POWER
        |=> divider_power_down == $past(reg_wdata[`DIV_PD_BIT])
            && reference_detector_off == $past(reg_wdata[`RDET_PD_BIT])
            && temp_converter_off == $past(reg_wdata[`TEMP_PD_BIT]);
    endproperty
    a_power_bits: assert property (p_power_bits) else $error("power-down bits wrong");

    property p_rdet_kept;
        @(posedge ref_clk) disable iff (!resetn)
        !(reg_wr && reg_addr == `OFS_OUTPUT_SWING_POWER) |=> $stable(reference_detector_off);
    endproperty
    a_rdet_kept: assert property (p_rdet_kept) else $error("detector bit moved unwritten");

    property p_temp_kept;
        @(posedge ref_clk) disable iff (!resetn)
        !(reg_wr && reg_addr == `OFS_OUTPUT_SWING_POWER) |=> $stable(temp_converter_off);
    endproperty
    a_temp_kept: assert property (p_temp_kept) else $error("temperature bit moved unwritten");

    // one idle cycle between write and read, as a byte host issues them
    property p_readback;
        @(posedge ref_clk) disable iff (!resetn)
        reg_wr && reg_addr == `OFS_FEEDBACK_DELAY_INVERT ##1 !reg_wr
        ##1 reg_rd && !reg_wr && reg_addr == `OFS_FEEDBACK_DELAY_INVERT
        |=> reg_rvalid && reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_readback: assert property (p_readback) else $error("readback differs from write");

    property p_buffer_hold;
        @(posedge ref_clk) disable iff (!resetn)
        buffer_enable && !buffer_update
        |=> $stable(bleed_current) && $stable(feedback_delay_code) && $stable(reference_delay_code);
    endproperty
    a_buffer_hold: assert property (p_buffer_hold) else $error("buffered field moved without update");

    property p_buffer_load;
        @(posedge ref_clk) disable iff (!resetn)
        buffer_update |=> {bleed_current, output_clock_inversion, feedback_delay_code, reference_delay_code}
            == $past({bleed_current_upper, pump_bleed_control[`BLEED_LOW_MSB:`BLEED_LOW_LSB],
                      feedback_delay_invert, reference_delay_level[`DELAY_MSB:`DELAY_LSB]});
    endproperty
    a_buffer_load: assert property (p_buffer_load) else $error("update pulse did not load fields");

    property p_unbuffered_follow;
        @(posedge ref_clk) disable iff (!resetn)
        !buffer_enable |=> {bleed_current, output_clock_inversion, feedback_delay_code, reference_delay_code}
            == $past({bleed_current_upper, pump_bleed_control[`BLEED_LOW_MSB:`BLEED_LOW_LSB],
                      feedback_delay_invert, reference_delay_level[`DELAY_MSB:`DELAY_LSB]});
    endproperty
    a_unbuffered_follow: assert property (p_unbuffered_follow) else $error("unbuffered fields lag");

    property p_rvalid_pulse;
        @(posedge ref_clk) disable iff (!resetn)
        1'b1 |=> reg_rvalid == $past(reg_rd);
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer not one cycle after strobe");

    property p_rdata_hold;
        @(posedge ref_clk) disable iff (!resetn)
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

    property p_unmapped_read;
        @(posedge ref_clk) disable iff (!resetn)
        reg_rd && (reg_addr < `OFS_PUMP_BLEED_CONTROL || reg_addr > `OFS_OUTPUT_SWING_POWER)
        |=> reg_rdata == '0;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

    property p_unmapped_write;
        @(posedge ref_clk) disable iff (!resetn)
        reg_wr && (reg_addr < `OFS_PUMP_BLEED_CONTROL || reg_addr > `OFS_OUTPUT_SWING_POWER)
        |=> $stable({pump_bleed_control, bleed_current_upper, feedback_delay_invert,
                     reference_delay_level, output_swing_power});
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed a register");

    property p_regs_kept;
        @(posedge ref_clk) disable iff (!resetn)
        !reg_wr |=> $stable({pump_bleed_control, bleed_current_upper, feedback_delay_invert,
                             reference_delay_level, output_swing_power});
    endproperty
    a_regs_kept: assert property (p_regs_kept) else $error("register moved without a write");

    property p_pump_code;
        @(posedge ref_clk) disable iff (!resetn)
        reg_wr && reg_addr == `OFS_PUMP_BLEED_CONTROL
        |=> pump_current_code == $past(reg_wdata[`PUMP_CUR_MSB:`PUMP_CUR_LSB]);
    endproperty
    a_pump_code: assert property (p_pump_code) else $error("pump current code wrong");

    property p_cal_off;
        @(posedge ref_clk) disable iff (!resetn)
        reg_wr && reg_addr == `OFS_OUTPUT_SWING_POWER |=> cal_dac_off == $past(reg_wdata[`CALDAC_PD_BIT]);
    endproperty
    a_cal_off: assert property (p_cal_off) else $error("calibration converter bit wrong");

    property p_dir_kept;
        @(posedge ref_clk) disable iff (!resetn)
        !(reg_wr && reg_addr == `OFS_PUMP_BLEED_CONTROL) |=> $stable(bleed_direction);
    endproperty
    a_dir_kept: assert property (p_dir_kept) else $error("bleed direction moved unwritten");

    property p_en_kept;
        @(posedge ref_clk) disable iff (!resetn)
        !(reg_wr && reg_addr == `OFS_PUMP_BLEED_CONTROL) |=> $stable(bleed_enable);
    endproperty
    a_en_kept: assert property (p_en_kept) else $error("bleed enable moved unwritten");

    property p_div_kept;
        @(posedge ref_clk) disable iff (!resetn)
        !(reg_wr && reg_addr == `OFS_OUTPUT_SWING_POWER) |=> $stable(divider_power_down);
    endproperty
    a_div_kept: assert property (p_div_kept) else $error("divider power bit moved unwritten");

    property p_level_kept;
        @(posedge ref_clk) disable iff (!resetn)
        !(reg_wr && reg_addr == `OFS_REFERENCE_DELAY_LEVEL) |=> $stable(io_logic_level_select);
    endproperty
    a_level_kept: assert property (p_level_kept) else $error("logic level moved unwritten");

    c_buffered_update: cover property (@(posedge ref_clk) disable iff (!resetn)
        buffer_enable && reg_wr ##[1:8] buffer_update);
    c_unbuffered_write: cover property (@(posedge ref_clk) disable iff (!resetn)
        !buffer_enable && reg_wr && reg_addr == `OFS_BLEED_CURRENT_UPPER);
    c_detector_on: cover property (@(posedge ref_clk) disable iff (!resetn) $fell(reference_detector_off));
    c_unmapped_read: cover property (@(posedge ref_clk) disable iff (!resetn)
        reg_rd && reg_addr > `OFS_OUTPUT_SWING_POWER);
    c_readback: cover property (@(posedge ref_clk) disable iff (!resetn)
        reg_wr ##2 reg_rd && reg_addr == `OFS_FEEDBACK_DELAY_INVERT);
endmodule

// *** verification/host_model.sv ***
// Purpose: host software model on the byte register port
// Assumes: one access at a time, strobes one cycle wide
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
module host_model
    import pump_pkg::*;
(
    input wire logic ref_clk,
    output reg_addr_t reg_addr,
    output reg_byte_t reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire reg_byte_t reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic write(input reg_addr_t a, input reg_byte_t d);
        if (a == 8'h19) d[7:6] = 2'b00;
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // answer is awaited a few cycles only, the caller counts a miss
    task automatic read(input reg_addr_t a, output reg_byte_t d, output bit ok);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (reg_rvalid === 1'b1) ok = 1'b1;
            else @(posedge ref_clk) #1;
        end
        d = reg_rdata;
    endtask
endmodule

// *** verification/pump_delay_power_cfg_regs_test.sv ***
// Purpose: self-checking bench of the configuration registers
// Assumes: buffered outputs settle within three cycles of a write
// Notes: model keeps shadow and active copies as integers
`timescale 1ns/1ps
module pump_delay_power_cfg_regs_test;
    import pump_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic buffer_enable = 1'b0;
    logic buffer_update = 1'b0;
    reg_addr_t reg_addr;
    reg_byte_t reg_wdata, reg_rdata, rd;
    logic reg_wr, reg_rd, reg_rvalid, bleed_direction, bleed_enable, output_clock_inversion;
    logic [3:0] pump_current_code;
    bleed_code_t bleed_current;
    delay_code_t feedback_delay_code, reference_delay_code;
    logic io_logic_level_select, divider_power_down, reference_detector_off, temp_converter_off, cal_dac_off;
    logic [1:0] output_swing_code;
    int error_cnt = 0;
    int checks_done = 0;
    int mdl[5] = '{0, 0, 0, 0, 'h04};
    int act[5] = '{0, 0, 0, 0, 'h04};
    bit ok;
    pump_delay_power_cfg_regs DUT (.*);
    host_model host (.*);
    initial forever #50 ref_clk = ~ref_clk;
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input int a, input int d);
        d = (a == 'h19) ? d & 'h3f : d & 'hff;
        host.write(8'(a), 8'(d));
        if (a >= 'h15 && a <= 'h19) begin
            mdl[a - 'h15] = d;
            if (!buffer_enable) act[a - 'h15] = d;
        end
    endtask
    // unmapped places read back as zero
    task automatic chk_rd(input int a);
        host.read(8'(a), rd, ok);
        if (!ok) begin
            error_cnt++;
            final_report();
        end
        chk("rdata", rd, (a >= 'h15 && a <= 'h19) ? mdl[a - 'h15] : 0);
    endtask
    task automatic chk_outs;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("pump", pump_current_code, mdl[0][3:0]);
        chk("bleed", bleed_current, {act[1][7:0], act[0][7:6]});
        chk("dir", bleed_direction, mdl[0][5]);
        chk("ben", bleed_enable, mdl[0][4]);
        chk("inv", output_clock_inversion, act[2][7]);
        chk("fdel", feedback_delay_code, act[2][6:0]);
        chk("rdel", reference_delay_code, act[3][6:0]);
        chk("lvl", io_logic_level_select, mdl[3][7]);
        chk("swing", output_swing_code, mdl[4][5:4]);
        chk("div", divider_power_down, mdl[4][3]);
        chk("rdet", reference_detector_off, mdl[4][2]);
        chk("temp", temp_converter_off, mdl[4][1]);
        chk("cal", cal_dac_off, mdl[4][0]);
    endtask
    initial begin
        void'($urandom(32'h48dfea2a));
        repeat (20) @(posedge ref_clk);
        #1 resetn = 1'b1;
        for (int a = 'h15; a <= 'h1a; a++) chk_rd(a);
        chk_outs();
        $display("test reset done");
        repeat (8) begin
            for (int a = 'h15; a <= 'h19; a++) wr(a, $urandom);
            chk_outs();
            for (int a = 'h15; a <= 'h19; a++) chk_rd(a);
            wr('h17, $urandom);
            chk_rd('h17);
        end
        $display("test random done");
        wr('h1a, 'hff);
        wr('h14, 'h5a);
        for (int a = 'h14; a <= 'h1a; a++) chk_rd(a);
        chk_outs();
        $display("test unmapped done");
        // buffered: actives must hold until the update pulse
        buffer_enable = 1'b1;
        for (int a = 'h15; a <= 'h18; a++) wr(a, $urandom);
        chk_outs();
        @(posedge ref_clk);
        #1 buffer_update = 1'b1;
        @(posedge ref_clk);
        #1 buffer_update = 1'b0;
        act = mdl;
        chk_outs();
        buffer_enable = 1'b0;
        $display("test buffered done");
        // detector on, then a mid-run reset must power it down again
        wr('h19, 'h00);
        chk_outs();
        @(posedge ref_clk);
        #1 resetn = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 resetn = 1'b1;
        mdl = '{0, 0, 0, 0, 'h04};
        act = mdl;
        for (int a = 'h15; a <= 'h19; a++) chk_rd(a);
        chk_outs();
        $display("test second reset done");
        final_report();
    end
endmodule
